// ==== cpcr_regs.v ====
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "cpcr_map.vh"

module cpcr_regs #(
    parameter NPORT = 5, // All slave ports
    parameter NLITE = 3, // Lite ports occupy indices 0..NLITE-1
    parameter AW = 12 // APB address width
) (
    input wire pclk, // APB clock, 100 MHz
    input wire presetn, // Asynchronous reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction, 1 = write
    input wire [AW-1:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    input wire [2:0] pprot, // APB protection, bit 1 set = non-secure
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    input wire [NPORT-1:0] snoop_channel_present_in, // Strap per port
    input wire [NPORT-1:0] priority_force_in, // Read priority force per port
    input wire [NPORT-1:0] rd_regulator_en_in, // Regulator active per port
    input wire [4*NPORT-1:0] rd_regulator_qos_in, // Regulator values
    input wire [4*NPORT-1:0] arqos_in, // Incoming read priorities
    output reg [4*NPORT-1:0] arqos_out, // Outgoing read priorities
    output reg [NPORT-1:0] snoop_enable_out, // Effective snoop enables
    output reg [NPORT-1:0] dvm_enable_out, // Effective DISTRIBUTED_VM_MAINTENANCE enables
    input wire [NLITE-1:0] txn_write_in, // Lite txn is a write
    input wire [2*NLITE-1:0] txn_domain_in, // Lite txn domain
    input wire [4*NLITE-1:0] txn_snoop_in, // Lite txn snoop type
    input wire [2*NLITE-1:0] txn_burst_in, // Lite txn burst type
    input wire [NLITE-1:0] txn_device_in, // Lite txn is device type
    input wire [NLITE-1:0] txn_barrier_in, // Lite txn is a barrier
    input wire [NLITE-1:0] txn_dvm_in, // Lite txn is a DISTRIBUTED_VM_MAINTENANCE message
    input wire [NLITE-1:0] txn_lock_in, // Lite txn is exclusive
    output reg [2*NLITE-1:0] txn_domain_out, // Rewritten domain
    output reg [4*NLITE-1:0] txn_snoop_out, // Rewritten snoop type
    output reg [NLITE-1:0] txn_lock_out, // Rewritten exclusive flag
    output reg [NLITE-1:0] txn_excl_okay_out // Answer exclusive with OKAY
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [2*NPORT-1:0] pin_s1_reg;
reg [2*NPORT-1:0] pin_s2_reg;
reg [2*NPORT-1:0] pin_s3_reg;
reg [2*NPORT-1:0] pin_lvl_reg;
reg [2:0] strap_cnt_reg;
reg strap_done_reg;
wire [NPORT-1:0] chan_present;
wire [NPORT-1:0] prio_force;

// A level only moves once two settled stages agree
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_s1_reg <= {2*NPORT{1'b0}};
        pin_s2_reg <= {2*NPORT{1'b0}};
        pin_s3_reg <= {2*NPORT{1'b0}};
        pin_lvl_reg <= {2*NPORT{1'b0}};
    end else begin
        pin_s1_reg <= {priority_force_in, snoop_channel_present_in};
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        pin_lvl_reg <= (pin_lvl_reg & (pin_s2_reg ^ pin_s3_reg))
            | (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg));
    end
end

assign chan_present = pin_lvl_reg[NPORT-1:0];
assign prio_force = pin_lvl_reg[2*NPORT-1:NPORT];

////////////////////////////////////////////////////////////////////////////////
// Support straps, taken once the synchroniser has filled after reset

reg [NPORT-1:0] dvm_sup_reg;
reg [NPORT-1:0] snp_sup_reg;
wire [NPORT-1:0] full_mask;
genvar g;

generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_mask
        assign full_mask[g] = (g >= NLITE);
    end
endgenerate

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        strap_cnt_reg <= 3'h0;
        strap_done_reg <= 1'b0;
        dvm_sup_reg <= {NPORT{1'b0}};
        snp_sup_reg <= {NPORT{1'b0}};
    end else if (!strap_done_reg) begin
        if (strap_cnt_reg == `CPCR_STRAP_CYCLES) begin
            strap_done_reg <= 1'b1;
            dvm_sup_reg <= chan_present;
            snp_sup_reg <= chan_present & full_mask;
        end else begin
            strap_cnt_reg <= strap_cnt_reg + 3'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register storage

reg [1:0] ctrl_ovr_reg;
reg ns_ok_reg;
reg [NPORT-1:0] snp_en_reg;
reg [NPORT-1:0] dvm_en_reg;
reg [2*NLITE-1:0] shr_reg;
reg [4*NPORT-1:0] rqos_reg;
wire [NPORT-1:0] dvm_eff;
wire [NPORT-1:0] snp_eff;

assign dvm_eff = dvm_sup_reg & {NPORT{~ctrl_ovr_reg[`CPCR_OVR_DVM]}};
assign snp_eff = snp_sup_reg & {NPORT{~ctrl_ovr_reg[`CPCR_OVR_SNP]}};

////////////////////////////////////////////////////////////////////////////////
// APB decode

wire [3:0] region;
wire [2:0] port_idx;
wire [2:0] sel;
wire port_ok;
wire lite_ok;
wire hit_coh;
wire hit_shr;
wire hit_rqos;
wire hit_ovr;
wire hit_sec;
wire secure_ok;
wire acc_err;
wire wr_fire;

assign region = paddr[`CPCR_REGION_MSB:`CPCR_REGION_LSB];
assign port_idx = paddr[`CPCR_PORT_MSB:`CPCR_PORT_LSB];
assign sel = paddr[`CPCR_SEL_MSB:`CPCR_SEL_LSB];
assign port_ok = (region == `CPCR_REGION_PORTS)
    && ({29'h0, port_idx} < NPORT);
assign lite_ok = port_ok && ({29'h0, port_idx} < NLITE);
assign hit_coh = port_ok && (sel == `CPCR_SEL_COH);
assign hit_shr = lite_ok && (sel == `CPCR_SEL_SHR);
assign hit_rqos = port_ok && (sel == `CPCR_SEL_RQOS);
assign hit_ovr = (region == `CPCR_REGION_GLOBAL)
    && (paddr[`CPCR_PORT_MSB:`CPCR_PORT_LSB] == 3'h0)
    && (sel == `CPCR_SEL_CTRL_OVR);
assign hit_sec = (region == `CPCR_REGION_GLOBAL)
    && (paddr[`CPCR_PORT_MSB:`CPCR_PORT_LSB] == 3'h0)
    && (sel == `CPCR_SEL_SEC_ACC);
assign secure_ok = !pprot[1] || ns_ok_reg;
// Blocked enable writes are silent; only bad addresses and denied
// secure accesses are reported
assign acc_err = !(hit_coh || hit_shr || hit_rqos || hit_ovr || hit_sec)
    || ((hit_shr || hit_rqos || hit_ovr) && !secure_ok)
    || (hit_sec && pprot[1]);
assign wr_fire = psel && penable && pready && pwrite && !acc_err;

////////////////////////////////////////////////////////////////////////////////
// Register writes

integer i;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_ovr_reg <= 2'h0;
        ns_ok_reg <= 1'b0;
        snp_en_reg <= {NPORT{1'b0}};
        dvm_en_reg <= {NPORT{1'b0}};
        shr_reg <= {2*NLITE{1'b0}};
        rqos_reg <= {4*NPORT{1'b0}};
    end else if (wr_fire) begin
        if (hit_ovr) begin
            ctrl_ovr_reg <= pwdata[`CPCR_OVR_DVM:`CPCR_OVR_SNP];
        end else if (hit_sec) begin
            ns_ok_reg <= pwdata[`CPCR_SEC_NS_OK];
        end else begin
            for (i = 0; i < NPORT; i = i + 1) begin
                if (port_idx == i[2:0]) begin
                    if (hit_coh && chan_present[i]) begin
                        if (snp_eff[i]) begin
                            snp_en_reg[i] <= pwdata[`CPCR_COH_SNP_EN];
                        end
                        if (dvm_eff[i]) begin
                            dvm_en_reg[i] <= pwdata[`CPCR_COH_DVM_EN];
                        end
                    end
                    if (hit_rqos) begin
                        rqos_reg[4*i +: 4] <=
                            pwdata[`CPCR_RQOS_MSB:`CPCR_RQOS_LSB];
                    end
                    if (hit_shr && i < NLITE) begin
                        shr_reg[2*i +: 2] <=
                            pwdata[`CPCR_SHR_MSB:`CPCR_SHR_LSB];
                    end
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, captured in the setup cycle so the bus outputs are flops

reg [31:0] rd_next;
integer r;

always @* begin
    rd_next = 32'h0;
    if (hit_ovr) begin
        rd_next[`CPCR_OVR_DVM:`CPCR_OVR_SNP] = ctrl_ovr_reg;
    end else if (hit_sec) begin
        rd_next[`CPCR_SEC_NS_OK] = ns_ok_reg;
    end else begin
        for (r = 0; r < NPORT; r = r + 1) begin
            if (port_idx == r[2:0]) begin
                if (hit_coh) begin
                    rd_next[`CPCR_COH_DVM_SUP] = dvm_eff[r];
                    rd_next[`CPCR_COH_SNP_SUP] = snp_eff[r];
                    rd_next[`CPCR_COH_DVM_EN] = dvm_en_reg[r]
                        & dvm_eff[r];
                    rd_next[`CPCR_COH_SNP_EN] = snp_en_reg[r]
                        & snp_eff[r];
                end
                if (hit_rqos) begin
                    rd_next[`CPCR_RQOS_MSB:`CPCR_RQOS_LSB] =
                        rqos_reg[4*r +: 4];
                    if (prio_force[r] && rd_regulator_en_in[r]) begin
                        rd_next[`CPCR_RQOS_LIVE_MSB:`CPCR_RQOS_LIVE_LSB] =
                            rd_regulator_qos_in[4*r +: 4];
                    end
                end
                if (hit_shr && r < NLITE) begin
                    rd_next[`CPCR_SHR_MSB:`CPCR_SHR_LSB] =
                        shr_reg[2*r +: 2];
                end
            end
        end
    end
    if (acc_err) begin
        rd_next = 32'h0;
    end
end

// One wait-free answer: pready rises in the first access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : rd_next;
        pready <= 1'b1;
        pslverr <= acc_err;
    end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Transaction attribute rewrite for lite ports

// Returns {excl_okay, lock, snoop[3:0], domain[1:0]}
function [7:0] cpcr_rewrite;
    input [1:0] mode;
    input wr;
    input [1:0] dom;
    input [3:0] snp;
    input [1:0] burst;
    input dev;
    input bar;
    input distributed_vm_maintenance;
    input lock;
    reg normal;
    begin
        normal = (burst != `CPCR_BURST_FIXED) && !dev && !bar && !distributed_vm_maintenance;
        cpcr_rewrite = {1'b0, lock, snp, dom};
        if (normal && mode == `CPCR_SHR_NON_SHARE) begin
            cpcr_rewrite[1:0] = `CPCR_DOM_NON_SHARE;
            if (wr && snp == `CPCR_SNP_WR_LINE_UNIQUE) begin
                cpcr_rewrite[5:2] = `CPCR_SNP_NOSNOOP;
            end
        end else if (normal && mode == `CPCR_SHR_SHARE) begin
            // Nosnoop codes stay; the shareable domain turns them into
            // ReadOnce and WriteUnique
            cpcr_rewrite[1:0] = `CPCR_DOM_INNER;
            cpcr_rewrite[6] = 1'b0;
            cpcr_rewrite[7] = lock && wr;
        end
    end
endfunction

reg [8*NLITE-1:0] rw_next;
integer t, u;

always @* begin
    rw_next = {8*NLITE{1'b0}};
    for (t = 0; t < NLITE; t = t + 1) begin
        rw_next[8*t +: 8] = cpcr_rewrite(shr_reg[2*t +: 2],
            txn_write_in[t], txn_domain_in[2*t +: 2], txn_snoop_in[4*t +: 4],
            txn_burst_in[2*t +: 2], txn_device_in[t], txn_barrier_in[t],
            txn_dvm_in[t], txn_lock_in[t]);
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        txn_domain_out <= {2*NLITE{1'b0}};
        txn_snoop_out <= {4*NLITE{1'b0}};
        txn_lock_out <= {NLITE{1'b0}};
        txn_excl_okay_out <= {NLITE{1'b0}};
    end else begin
        for (u = 0; u < NLITE; u = u + 1) begin
            txn_domain_out[2*u +: 2] <= rw_next[8*u +: 2];
            txn_snoop_out[4*u +: 4] <= rw_next[8*u+2 +: 4];
            txn_lock_out[u] <= rw_next[8*u+6];
            txn_excl_okay_out[u] <= rw_next[8*u+7];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read priority and enable outputs

integer q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        arqos_out <= {4*NPORT{1'b0}};
        snoop_enable_out <= {NPORT{1'b0}};
        dvm_enable_out <= {NPORT{1'b0}};
    end else begin
        snoop_enable_out <= snp_en_reg & snp_eff;
        dvm_enable_out <= dvm_en_reg & dvm_eff;
        for (q = 0; q < NPORT; q = q + 1) begin
            if (prio_force[q] && !rd_regulator_en_in[q]) begin
                arqos_out[4*q +: 4] <= rqos_reg[4*q +: 4];
            end else begin
                arqos_out[4*q +: 4] <= arqos_in[4*q +: 4];
            end
        end
    end
end

endmodule // cpcr_regs

// ==== cpcr_map.vh ====
`ifndef CPCR_MAP_VH
`define CPCR_MAP_VH

// Address map: paddr[11:8] region, paddr[7:5] port, paddr[4:2] register
`define CPCR_REGION_MSB 11
`define CPCR_REGION_LSB 8
`define CPCR_PORT_MSB 7
`define CPCR_PORT_LSB 5
`define CPCR_SEL_MSB 4
`define CPCR_SEL_LSB 2
`define CPCR_REGION_PORTS 4'h0
`define CPCR_REGION_GLOBAL 4'h1
`define CPCR_SEL_COH 3'h0
`define CPCR_SEL_SHR 3'h1
`define CPCR_SEL_RQOS 3'h2
`define CPCR_SEL_CTRL_OVR 3'h0
`define CPCR_SEL_SEC_ACC 3'h1

// Coherency control fields
`define CPCR_COH_DVM_SUP 31
`define CPCR_COH_SNP_SUP 30
`define CPCR_COH_DVM_EN 1
`define CPCR_COH_SNP_EN 0

// Control override and secure access fields
`define CPCR_OVR_SNP 0
`define CPCR_OVR_DVM 1
`define CPCR_SEC_NS_OK 0

// Shareability override field and values
`define CPCR_SHR_MSB 1
`define CPCR_SHR_LSB 0
`define CPCR_SHR_NONE 2'h0
`define CPCR_SHR_NONE_ALT 2'h1
`define CPCR_SHR_NON_SHARE 2'h2
`define CPCR_SHR_SHARE 2'h3

// Read priority override fields
`define CPCR_RQOS_MSB 3
`define CPCR_RQOS_LSB 0
`define CPCR_RQOS_LIVE_MSB 11
`define CPCR_RQOS_LIVE_LSB 8

// Transaction attribute encodings
`define CPCR_DOM_NON_SHARE 2'h0
`define CPCR_DOM_INNER 2'h1
`define CPCR_SNP_NOSNOOP 4'h0
`define CPCR_SNP_WR_LINE_UNIQUE 4'h1
`define CPCR_BURST_FIXED 2'h0

// Cycles after reset release before straps are taken
`define CPCR_STRAP_CYCLES 3'h4

`endif

// ==== cpcr_props.sv ====
`timescale 1ns/10ps
module cpcr_props #(
    parameter NPORT = 5,
    parameter NLITE = 3,
    parameter AW = 12
) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Direction
    input wire [AW-1:0] paddr, // Address
    input wire [31:0] prdata, // Read data
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire [NPORT-1:0] snoop_enable_out, // Snoop enables
    input wire [NLITE-1:0] txn_write_in, // Write flag
    input wire [2*NLITE-1:0] txn_domain_in, // Domain in
    input wire [4*NLITE-1:0] txn_snoop_in, // Snoop type in
    input wire [NLITE-1:0] txn_dvm_in, // Maintenance message
    input wire [NLITE-1:0] txn_lock_in, // Exclusive in
    input wire [2*NLITE-1:0] txn_domain_out, // Domain out
    input wire [4*NLITE-1:0] txn_snoop_out, // Snoop type out
    input wire [NLITE-1:0] txn_lock_out, // Exclusive out
    input wire [NLITE-1:0] txn_excl_okay_out // Exclusive answered OKAY
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_port = pready && !pwrite && paddr[11:8] == 4'h0;
    ////////////////////////////////////////////////////////////////////
    property p_rdy_next; psel && !penable |=> pready; endproperty
    a_rdy_next: assert property (p_rdy_next) else $error("pready late");
    property p_rdy_one; pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready held");
    property p_coh_rsvd; rd_port && paddr[4:2] == 3'h0 |->
        prdata[29:2] == 28'h0; endproperty
    a_coh_rsvd: assert property (p_coh_rsvd) else $error("coh rsvd");
    property p_shr_rsvd; rd_port && paddr[4:2] == 3'h1 |->
        prdata[31:2] == 30'h0; endproperty
    a_shr_rsvd: assert property (p_shr_rsvd) else $error("shr rsvd");
    property p_rq_rsvd; rd_port && paddr[4:2] == 3'h2 |->
        prdata[31:12] == 20'h0 && prdata[7:4] == 4'h0; endproperty
    a_rq_rsvd: assert property (p_rq_rsvd) else $error("rq rsvd");
    property p_lite_sup; rd_port && paddr[4:2] == 3'h0 &&
        paddr[7:5] < NLITE |-> !prdata[30]; endproperty
    a_lite_sup: assert property (p_lite_sup) else $error("lite sup");
    property p_lite_en; snoop_enable_out[NLITE-1:0] == '0; endproperty
    a_lite_en: assert property (p_lite_en) else $error("lite snoop");
    // Maintenance messages must cross untouched whatever the override
    property p_msg_pass; txn_dvm_in[0] |=>
        txn_domain_out[1:0] == $past(txn_domain_in[1:0]) &&
        txn_snoop_out[3:0] == $past(txn_snoop_in[3:0]) &&
        txn_lock_out[0] == $past(txn_lock_in[0]); endproperty
    a_msg_pass: assert property (p_msg_pass) else $error("msg altered");
    property p_excl; txn_excl_okay_out[0] |->
        $past(txn_lock_in[0] && txn_write_in[0]) && !txn_lock_out[0];
    endproperty
    a_excl: assert property (p_excl) else $error("excl okay");
    c_err: cover property (pready && pslverr);
    c_wr: cover property (pready && pwrite);
    c_excl: cover property (txn_excl_okay_out[0]);
endmodule // cpcr_props

bind cpcr_regs cpcr_props #(.NPORT(NPORT), .NLITE(NLITE), .AW(AW)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .snoop_enable_out(snoop_enable_out),
    .txn_write_in(txn_write_in), .txn_domain_in(txn_domain_in),
    .txn_snoop_in(txn_snoop_in), .txn_dvm_in(txn_dvm_in),
    .txn_lock_in(txn_lock_in), .txn_domain_out(txn_domain_out),
    .txn_snoop_out(txn_snoop_out), .txn_lock_out(txn_lock_out),
    .txn_excl_okay_out(txn_excl_okay_out));

// ==== coherency_port_control_regs_tb.sv ====
`timescale 1ns/10ps
module coherency_port_control_regs_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, r, r2, d;
    logic [2:0] pprot = 0, t_wr = 0, t_dev = 0, t_bar = 0, t_vmm = 0;
    logic [2:0] t_lock = 0;
    // Port 1 strap low: its control register must stay frozen
    logic [4:0] strap = 5'h1d, force_q = 0, reg_en = 0;
    logic [19:0] reg_qos = 0, aq_in = 0;
    logic [5:0] t_dom = 0, t_burst = 0;
    logic [11:0] t_snp = 0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [19:0] aq_out;
    wire [4:0] snp_en, vm_en;
    wire [5:0] o_dom;
    wire [11:0] o_snp;
    wire [2:0] o_lock, o_ok;
    integer fail_count = 0, n_tests = 0, seed = 32'h80b5, p, m;
    always #5 pclk = ~pclk;
    cpcr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .snoop_channel_present_in(strap), .priority_force_in(force_q),
        .rd_regulator_en_in(reg_en), .rd_regulator_qos_in(reg_qos),
        .arqos_in(aq_in), .arqos_out(aq_out), .snoop_enable_out(snp_en),
        .dvm_enable_out(vm_en), .txn_write_in(t_wr), .txn_domain_in(t_dom),
        .txn_snoop_in(t_snp), .txn_burst_in(t_burst), .txn_device_in(t_dev),
        .txn_barrier_in(t_bar), .txn_dvm_in(t_vmm), .txn_lock_in(t_lock),
        .txn_domain_out(o_dom), .txn_snoop_out(o_snp), .txn_lock_out(o_lock),
        .txn_excl_okay_out(o_ok));
    ////////////////////////////////////////////////////////////////////
    task chk(input logic [32:0] s, input logic [32:0] x);
        begin
            n_tests = n_tests + 1;
            if (s !== x) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t seen %h exp %h", $time, s, x);
            end
        end
    endtask
    // Entered just after an edge; an idle edge at the end keeps the
    // next call from assigning psel twice in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             input logic ns);
        integer k;
        begin
            {psel, penable, pwrite, paddr, pwdata, pprot} <=
                {2'b10, w, a, wd, 1'b0, ns, 1'b0};
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && k < 20) begin
                @(posedge pclk);
                k = k + 1;
            end
            if (k == 20) fail_count = fail_count + 1;
            rd = prdata;
            e = pslverr;
            {psel, penable} <= 2'b00;
            @(posedge pclk);
        end
    endtask
    function logic [31:0] exp_coh(input integer q, input logic en,
                                  input logic [1:0] ov);
        logic sd, ss;
        begin
            sd = strap[q] & ~ov[1];
            ss = strap[q] & (q >= 3) & ~ov[0];
            exp_coh = {sd, ss, 28'h0, sd & en, ss & en};
        end
    endfunction
    task coh_all(input logic en, input logic [1:0] ov);
        for (p = 0; p < 5; p++) begin
            apb(0, p * 32, 0, 0);
            chk(rd, exp_coh(p, en, ov));
            chk({e, vm_en[p], snp_en[p]}, exp_coh(p, en, ov) & 3);
        end
    endtask
    // Bits still allowed are written 1; blocked bits are written 0
    task blk(input logic [1:0] ov);
        begin
            apb(1, 12'h100, ov, 0);
            for (p = 0; p < 5; p++) begin
                apb(1, p * 32, {2'b11, 28'h0, ~ov}, 0);
                chk(e, 0);
            end
            coh_all(1, ov);
            // Lifting the override must bring back the kept enables
            apb(1, 12'h100, 0, 0);
            coh_all(1, 0);
        end
    endtask
    function logic [7:0] ex(input integer mo, input integer q);
        logic nn, w, l;
        begin
            w = t_wr[q];
            l = t_lock[q];
            nn = t_burst[2*q+:2] != 0 && !t_dev[q] && !t_bar[q] && !t_vmm[q];
            ex = {1'b0, l, t_snp[4*q+:4], t_dom[2*q+:2]};
            if (nn && mo == 2) begin
                ex[1:0] = 2'h0;
                if (w && t_snp[4*q+:4] == 4'h1) ex[5:2] = 4'h0;
            end
            if (nn && mo == 3) ex = {l & w, 1'b0, t_snp[4*q+:4], 2'h1};
        end
    endfunction
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fail_count = fail_count + 1;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        coh_all(0, 0);
        for (p = 0; p < 5; p++) begin
            apb(0, p * 32 + 4, 0, 0);
            chk({e, rd}, {p > 2, 32'h0});
            apb(0, p * 32 + 8, 0, 0);
            chk({e, rd}, 0);
        end
        $display("reset values done");
        for (m = 0; m < 5; m++) blk(m % 4);
        $display("enable blocking done");
        apb(1, 12'h004, 2, 1);
        chk(e, 1);
        apb(0, 12'h004, 0, 0);
        chk({e, rd}, 0);
        apb(0, 12'h008, 0, 1);
        chk({e, rd}, {1'b1, 32'h0});
        apb(1, 12'h104, 1, 0);
        apb(0, 12'h008, 0, 1);
        chk({e, rd}, 0);
        apb(1, 12'h104, 0, 1);
        chk(e, 1);
        apb(1, 12'h104, 0, 0);
        apb(0, 12'h0a0, 0, 0);
        chk(e, 1);
        $display("access refusal done");
        for (m = 0; m < 4; m++) begin
            for (p = 0; p < 3; p++) apb(1, p * 32 + 4, 32'hfffffff0 | m, 0);
            apb(0, 4, 0, 0);
            chk({e, rd}, m);
            repeat (40) begin
                r = $random(seed);
                r2 = $random(seed);
                // Exclusives stay on under forced sharing: deliberate misuse
                {t_lock, t_burst, t_snp, t_dom, t_wr} <= r[29:0];
                t_dev <= r2[2:0] & r2[5:3];
                t_bar <= r2[8:6] & r2[11:9];
                t_vmm <= r2[14:12] & r2[17:15];
                @(posedge pclk);
                #1;
                for (p = 0; p < 3; p++)
                    chk({o_ok[p], o_lock[p], o_snp[4*p+:4], o_dom[2*p+:2]},
                        ex(m, p));
                @(posedge pclk);
            end
        end
        $display("override rewrite done");
        d = $random(seed);
        r = $random(seed);
        apb(1, 12'h048, d, 0);
        apb(0, 12'h048, 0, 0);
        chk({e, rd}, {29'h0, d[3:0]});
        aq_in <= r[19:0];
        reg_qos <= r[31:12];
        force_q <= 5'h04;
        repeat (8) @(posedge pclk);
        #1;
        chk(aq_out, {aq_in[19:12], d[3:0], aq_in[7:0]});
        @(posedge pclk);
        reg_en <= 5'h04;
        repeat (3) @(posedge pclk);
        apb(0, 12'h048, 0, 0);
        chk({e, rd}, {21'h0, reg_qos[11:8], 4'h0, d[3:0]});
        chk(aq_out, aq_in);
        reg_en <= 5'h00;
        force_q <= 5'h00;
        repeat (8) @(posedge pclk);
        #1;
        chk(aq_out, aq_in);
        $display("read priority done");
        end_of_test;
    end
endmodule // coherency_port_control_regs_tb
